// ---- arpq_host.sv ----
/*
  host model: the processor that drains and configures the queue
  through the plain register port. assumes the queue answers a read
  in the next cycle and never makes the host wait.
*/
`timescale 1ns/1ps
module arpq_host (
  input  wire logic        i_clk,   // system clock
  input  wire logic [31:0] i_rdata, // read data
  output logic      [7:0]  o_addr,  // register offset
  output logic      [31:0] o_wdata, // write data
  output logic             o_wr,    // write strobe
  output logic             o_rd     // read strobe
);
  // ==========================================================
  // idle bus at time zero
  initial begin
    o_addr  = 8'h00;
    o_wdata = 32'h0000_0000;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end
  // ==========================================================
  // one-cycle write; data toggled after so stale data never matches
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_wdata <= ~d;
  endtask : wr
  // one-cycle read; data taken in the cycle after the strobe only
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    @(posedge i_clk);
    d = i_rdata;
  endtask : rd
endmodule : arpq_host

// ---- arpq_pkg.sv ----
/*
  shared constants and types of the asynchronous receive packet queue.
  assumes nothing of its surroundings; used by the queue, its status encoder and the bench.
*/
package arpq_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFF_SPLIT = 8'h08; // split transaction enable
  localparam logic [7:0] OFF_STAT  = 8'h30; // queue status and config
  localparam logic [7:0] OFF_DATA  = 8'h80; // data port, read pops
  // ==========================================================
  // register fields
  localparam int BIT_SPLIT_EN = 0;  // split enable in OFF_SPLIT
  localparam int BIT_RX_EN    = 0;  // queue accepts packets
  localparam int BIT_OVF_CLR  = 1;  // write 1 clears overflow
  localparam int BIT_FLUSH    = 2;  // write 1 empties the queue
  localparam int BIT_EMPTY    = 8;  // read only
  localparam int BIT_FULL     = 9;  // read only
  localparam int BIT_OVF      = 10; // sticky overflow
  localparam int LVL_LSB      = 16; // fill level, read only
  localparam logic RX_EN_RST    = 1'b1;
  localparam logic SPLIT_EN_RST = 1'b0;
  // ==========================================================
  // token and header layout
  localparam int STATUS_LSB = 28; // status in four top bits
  localparam int SPD_LSB    = 16; // speed, two bits
  localparam int ACK_LSB    = 0;  // ack in four low bits
  localparam int TCODE_LSB  = 4;  // tcode in first quadlet
  localparam int PRI_W      = 4;  // priority width, bottom bits
  localparam logic [2:0] QUAD_HDR_N = 3'h3; // header words, quadlet
  localparam logic [2:0] BLK_HDR_N  = 3'h4; // header words, block
  // ==========================================================
  // codes
  localparam logic [3:0] ST_COMPLETE = 4'h0;
  localparam logic [3:0] ST_NO_ACK   = 4'h1;
  localparam logic [3:0] ST_ACK_ERR  = 4'h2;
  localparam logic [3:0] ST_ACK_MISS = 4'h3;
  localparam logic [3:0] ST_ORB_BAD  = 4'h4;
  localparam logic [3:0] ST_ORB_OK   = 4'h5;
  localparam logic [3:0] TC_WR_RESP  = 4'h2;
  localparam logic [3:0] TC_RD_QUAD  = 4'h4;
  localparam logic [3:0] TC_RD_BLOCK = 4'h5;
  // how the packet's transaction ended
  typedef enum logic [2:0] {
    ARPQ_C_COMPLETE, ARPQ_C_NO_ACK, ARPQ_C_PEND, ARPQ_C_OTHER,
    ARPQ_C_MISSING, ARPQ_C_ORB_BAD, ARPQ_C_ORB_OK
  } arpq_cond_t;
  // where the packet came from
  typedef enum logic [1:0] {
    ARPQ_S_TX_RESP, ARPQ_S_NODE_REQ, ARPQ_S_OTHER
  } arpq_src_t;
endpackage : arpq_pkg

// ---- arpq_q_if.sv ----
/*
  carrier between the queue control and its quadlet store.
  assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface arpq_q_if #(parameter int LW = 5);
  logic          push;  // store wdata
  logic [31:0]   wdata; // quadlet in
  logic          pop;   // drop head
  logic          flush; // empty all
  logic [31:0]   head;  // oldest quadlet
  logic          empty; // nothing stored
  logic          full;  // no room
  logic [LW-1:0] level; // words stored
  modport ctl (output push, wdata, pop, flush,
               input head, empty, full, level);
  modport mem (input push, wdata, pop, flush,
               output head, empty, full, level);
endinterface : arpq_q_if

// ---- arpq_queue.sv ----
/*
  asynchronous receive packet queue: takes finished packets from
  the link core, writes a token quadlet then the header and the
  payload that is kept, and lets software drain quadlets through
  a data port. assumes link inputs are on i_clk already, a packet
  start never shares a cycle with a quadlet, and quadlets of a
  packet arrive after its start in raw bus order.
*/
// The plain strobed port was decided locally.
`timescale 1ns/1ps

module arpq_queue #(
  parameter int DEPTH = 16 // quadlets held
) (
  input  wire logic                 i_clk,          // system clock
  input  wire logic                 i_srst,         // sync reset, high
  input  wire logic                 i_ce,           // clock enable
  input  wire logic [7:0]           i_addr,         // register offset
  input  wire logic [31:0]          i_wdata,        // write data
  input  wire logic                 i_wr,           // write strobe
  input  wire logic                 i_rd,           // read strobe
  output logic      [31:0]          o_rdata,        // read data, next cycle
  output logic                      o_not_empty,    // queue holds data
  input  wire logic                 i_pkt_start,    // packet done, pulse
  input  wire arpq_pkg::arpq_src_t  i_pkt_src,      // packet origin
  input  wire logic                 i_pkt_to_agent, // bound for agent
  input  wire arpq_pkg::arpq_cond_t i_pkt_cond,     // how it ended
  input  wire logic                 i_pkt_is_req,   // sent one was request
  input  wire logic [1:0]           i_pkt_spd,      // receive speed
  input  wire logic [3:0]           i_pkt_ack,      // ack code
  input  wire logic                 i_q_valid,      // quadlet strobe
  input  wire logic [31:0]          i_q_data,       // raw quadlet
  input  wire logic                 i_q_last        // last of packet
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = AW + 1;

  // ==========================================================
  // declarations
  typedef enum logic [1:0] {ARPQ_IDLE, ARPQ_BODY, ARPQ_DROP} arpq_st_t;
  arpq_st_t    state;     // packet framing
  logic        rx_en;     // accepting packets
  logic        split_en;  // split transactions on
  logic        ovf;       // sticky overflow
  logic [2:0]  q_idx;     // quadlet index, saturates
  logic [3:0]  pkt_tcode; // tcode seen in first quadlet
  logic [3:0]  status;    // encoded token status
  logic        accept;    // start is queued
  logic        keep;      // body quadlet is stored
  logic [3:0]  cur_tc;    // tcode for this quadlet
  logic [31:0] token;     // token quadlet
  logic [31:0] body;      // quadlet as stored
  logic        push_try;  // word wants in
  logic        wr_stat;   // status register write
  logic [31:0] next_rdata;

  arpq_q_if #(.LW(LW)) q ();

  // ==========================================================
  // submodules
  arpq_status_enc u_enc (
    .i_cond     (i_pkt_cond),
    .i_is_req   (i_pkt_is_req),
    .i_split_en (split_en),
    .o_status   (status)
  );

  arpq_store #(.DEPTH(DEPTH)) u_store (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .i_ce   (i_ce),
    .q      (q)
  );

  // ==========================================================
  // acceptance and formatting
  // response to own send or a request, either only if not meant for the agent
  assign accept = rx_en && !i_pkt_to_agent
               && (i_pkt_src == arpq_pkg::ARPQ_S_TX_RESP
                || i_pkt_src == arpq_pkg::ARPQ_S_NODE_REQ);

  // token built from status, speed and ack
  always_comb begin
    token = '0;
    token[arpq_pkg::STATUS_LSB +: 4] = status;
    token[arpq_pkg::SPD_LSB +: 2]    = i_pkt_spd;
    token[arpq_pkg::ACK_LSB +: 4]    = i_pkt_ack;
  end

  // first quadlet carries the tcode it is judged by
  assign cur_tc = (q_idx == 3'h0) ? i_q_data[arpq_pkg::TCODE_LSB +: 4]
                                  : pkt_tcode;

  // header words pass; payload only where data travels
  always_comb begin
    keep = 1'b1;
    if ((cur_tc == arpq_pkg::TC_RD_QUAD || cur_tc == arpq_pkg::TC_WR_RESP)
        && q_idx >= arpq_pkg::QUAD_HDR_N) begin
      keep = 1'b0;
    end
    if (cur_tc == arpq_pkg::TC_RD_BLOCK && q_idx >= arpq_pkg::BLK_HDR_N) begin
      keep = 1'b0;
    end
  end

  // cable priority forced to zero in the first header word
  always_comb begin
    body = i_q_data;
    if (q_idx == 3'h0) begin
      body[arpq_pkg::PRI_W-1:0] = '0;
    end
  end

  // one word per cycle: token at start, then body quadlets
  assign push_try = (state == ARPQ_IDLE && i_pkt_start && accept)
                 || (state == ARPQ_BODY && i_q_valid && keep);
  assign q.push  = i_ce && push_try && !q.full;
  assign q.wdata = (state == ARPQ_IDLE) ? token : body;

  // ==========================================================
  // packet framing
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state <= ARPQ_IDLE;
    end else if (i_ce) begin
      case (state)
        ARPQ_IDLE: begin
          if (i_pkt_start) begin
            state <= accept ? ARPQ_BODY : ARPQ_DROP;
          end
        end
        ARPQ_BODY, ARPQ_DROP: begin
          if (i_q_valid && i_q_last) begin
            state <= ARPQ_IDLE;
          end
        end
        default: state <= ARPQ_IDLE;
      endcase
    end
  end

  // quadlet index and latched tcode
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      q_idx     <= '0;
      pkt_tcode <= '0;
    end else if (i_ce) begin
      if (state == ARPQ_IDLE) begin
        q_idx <= '0;
      end else if (i_q_valid) begin
        // saturating: only "past the header" matters
        q_idx <= (q_idx == 3'h7) ? q_idx : q_idx + 3'h1;
        if (q_idx == 3'h0) begin
          pkt_tcode <= i_q_data[arpq_pkg::TCODE_LSB +: 4];
        end
      end
    end
  end

  // ==========================================================
  // register writes
  assign wr_stat = i_wr && (i_addr == arpq_pkg::OFF_STAT);

  // configuration bits
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rx_en    <= arpq_pkg::RX_EN_RST;
      split_en <= arpq_pkg::SPLIT_EN_RST;
    end else if (i_ce) begin
      if (wr_stat) begin
        rx_en <= i_wdata[arpq_pkg::BIT_RX_EN];
      end
      if (i_wr && i_addr == arpq_pkg::OFF_SPLIT) begin
        split_en <= i_wdata[arpq_pkg::BIT_SPLIT_EN];
      end
    end
  end

  // overflow: a lost word sets it, and the set beats a clear
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ovf <= 1'b0;
    end else if (i_ce) begin
      if (push_try && q.full) begin
        ovf <= 1'b1;
      end else if (wr_stat && i_wdata[arpq_pkg::BIT_OVF_CLR]) begin
        ovf <= 1'b0;
      end
    end
  end

  // flush drops stored words; a packet in flight keeps going
  assign q.flush = wr_stat && i_wdata[arpq_pkg::BIT_FLUSH];
  // data port read pops the head
  // an empty pop is refused in the store, so reading is safe
  assign q.pop = i_ce && i_rd && i_addr == arpq_pkg::OFF_DATA;

  // ==========================================================
  // register reads
  always_comb begin
    next_rdata = '0;
    case (i_addr)
      arpq_pkg::OFF_SPLIT: next_rdata[arpq_pkg::BIT_SPLIT_EN] = split_en;
      arpq_pkg::OFF_STAT: begin
        next_rdata[arpq_pkg::BIT_RX_EN] = rx_en;
        next_rdata[arpq_pkg::BIT_EMPTY] = q.empty;
        next_rdata[arpq_pkg::BIT_FULL]  = q.full;
        next_rdata[arpq_pkg::BIT_OVF]   = ovf;
        next_rdata[arpq_pkg::LVL_LSB +: LW] = q.level;
      end
      // empty queue reads zero rather than stale data
      arpq_pkg::OFF_DATA: next_rdata = q.empty ? '0 : q.head;
      default: next_rdata = '0;
    endcase
  end

  // read data held only in the cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rdata <= '0;
    end else if (i_ce) begin
      o_rdata <= i_rd ? next_rdata : '0;
    end
  end

  // level flag for the host
  // counts a same-cycle push so the flag never lags the token
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_not_empty <= 1'b0;
    end else if (i_ce) begin
      o_not_empty <= !q.empty || q.push;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  // which packets enter the queue
  a_resp_queued: assert property (
    i_ce && state == ARPQ_IDLE && i_pkt_start && rx_en && !q.full
    && i_pkt_src == arpq_pkg::ARPQ_S_TX_RESP |-> q.push)
    else $error("response not queued");

  a_agent_dropped: assert property (
    i_ce && state == ARPQ_IDLE && i_pkt_start && i_pkt_to_agent
    |=> state == ARPQ_DROP && !q.push)
    else $error("agent packet queued");

  a_drop_silent: assert property (
    state == ARPQ_DROP |-> !q.push)
    else $error("dropped packet stored");

  a_disabled_drop: assert property (
    i_ce && state == ARPQ_IDLE && i_pkt_start && !rx_en |=> state == ARPQ_DROP)
    else $error("disabled queue took packet");

  // host side of the data port
  a_port_pops: assert property (
    i_ce && i_rd && i_addr == arpq_pkg::OFF_DATA && !q.empty
    |=> o_rdata == $past(q.head) && q.level <= $past(q.level))
    else $error("data port read wrong");

  a_empty_read: assert property (
    i_ce && i_rd && i_addr == arpq_pkg::OFF_DATA && q.empty |=> o_rdata == '0)
    else $error("empty read not zero");

  a_rdata_idle: assert property (
    i_ce && !i_rd |=> o_rdata == '0)
    else $error("read data held too long");

  // token and header formatting
  a_token_fields: assert property (
    q.push && state == ARPQ_IDLE
    |-> q.wdata[31:28] == status && q.wdata[3:0] == i_pkt_ack)
    else $error("token layout wrong");

  a_token_spd: assert property (
    q.push && state == ARPQ_IDLE |-> q.wdata[17:16] == i_pkt_spd)
    else $error("token speed wrong");

  a_token_resv: assert property (
    q.push && state == ARPQ_IDLE |-> q.wdata[27:18] == '0 && q.wdata[15:4] == '0)
    else $error("token reserved bits set");

  a_prior_zero: assert property (
    q.push && state == ARPQ_BODY && q_idx == 3'h0 |-> q.wdata[3:0] == 4'h0)
    else $error("priority not zero");

  // payload kept only where data travels
  a_quad_omit: assert property (
    state == ARPQ_BODY && q_idx >= 3'h3 && pkt_tcode == 4'h4 |-> !q.push)
    else $error("read request payload stored");

  a_block_omit: assert property (
    state == ARPQ_BODY && q_idx >= 3'h4 && pkt_tcode == 4'h5 |-> !q.push)
    else $error("block read payload stored");

  // status encoding; pending is the subtle one
  a_split_code: assert property (
    i_pkt_cond == arpq_pkg::ARPQ_C_PEND && i_pkt_is_req
    |-> status == (split_en ? 4'h0 : 4'h2))
    else $error("pending status wrong");

  a_miss_code: assert property (
    i_pkt_cond == arpq_pkg::ARPQ_C_MISSING |-> status == 4'h3)
    else $error("missing ack status wrong");

  // overflow and flush; a clear right after the set is legal
  a_ovf_sticky: assert property (
    i_ce && push_try && q.full
    |=> ovf ##1 (ovf || $past(wr_stat && i_wdata[arpq_pkg::BIT_OVF_CLR])))
    else $error("overflow not held");

  a_flush_empties: assert property (
    i_ce && q.flush |=> q.empty)
    else $error("flush left words");

  // main scenarios worth seeing once
  c_token: cover property (q.push && state == ARPQ_IDLE);
  c_pop: cover property (q.pop && !q.empty);
  c_overflow: cover property (push_try && q.full);
  c_drop: cover property (state == ARPQ_DROP && i_q_valid && i_q_last);
  c_flush: cover property (i_ce && q.flush);
endmodule : arpq_queue

// ---- arpq_status_enc.sv ----
/*
  maps how a transaction ended onto the token status code.
  assumes the condition is valid in the cycle it is read.
*/
`timescale 1ns/1ps
module arpq_status_enc (
  input  wire arpq_pkg::arpq_cond_t i_cond,     // how it ended
  input  wire logic                 i_is_req,   // sent packet was a request
  input  wire logic                 i_split_en, // split transactions on
  output logic [3:0]                o_status    // token status code
);
  // ==========================================================
  // code selection
  always_comb begin
    case (i_cond)
      arpq_pkg::ARPQ_C_COMPLETE: o_status = arpq_pkg::ST_COMPLETE;
      arpq_pkg::ARPQ_C_NO_ACK:   o_status = arpq_pkg::ST_NO_ACK;
      // pending on a request ends it only with split on
      arpq_pkg::ARPQ_C_PEND: begin
        if (i_is_req && i_split_en) begin
          o_status = arpq_pkg::ST_COMPLETE;
        end else begin
          o_status = arpq_pkg::ST_ACK_ERR;
        end
      end
      arpq_pkg::ARPQ_C_OTHER:    o_status = arpq_pkg::ST_ACK_ERR;
      arpq_pkg::ARPQ_C_MISSING:  o_status = arpq_pkg::ST_ACK_MISS;
      arpq_pkg::ARPQ_C_ORB_BAD:  o_status = arpq_pkg::ST_ORB_BAD;
      arpq_pkg::ARPQ_C_ORB_OK:   o_status = arpq_pkg::ST_ORB_OK;
      default:                   o_status = arpq_pkg::ST_ACK_ERR;
    endcase
  end
endmodule : arpq_status_enc

// ---- arpq_store.sv ----
/*
  quadlet store of the receive queue: flip-flop ring, one word in
  and one out per cycle. assumes i_ce freezes it; push on full is
  refused here as well as by the caller's own check.
*/
`timescale 1ns/1ps
module arpq_store #(
  parameter int DEPTH = 16,            // quadlets held
  parameter int AW    = $clog2(DEPTH), // index width
  parameter int LW    = AW + 1         // level width
) (
  input  wire logic i_clk,  // system clock
  input  wire logic i_srst, // sync reset, high
  input  wire logic i_ce,   // clock enable
  arpq_q_if.mem     q       // control side
);
  // ==========================================================
  // storage
  logic [31:0]   mem [DEPTH]; // words, no reset needed
  logic [AW-1:0] wr_ptr;      // next free slot
  logic [AW-1:0] rd_ptr;      // oldest word
  logic [LW-1:0] count;       // words stored
  logic          do_push;     // accepted write
  logic          do_pop;      // accepted read

  assign do_push = q.push && (count != LW'(DEPTH));
  assign do_pop  = q.pop && (count != '0);
  assign q.head  = mem[rd_ptr];
  assign q.empty = (count == '0);
  assign q.full  = (count == LW'(DEPTH));
  assign q.level = count;

  // write slot
  always_ff @(posedge i_clk) begin
    if (i_ce && do_push) begin
      mem[wr_ptr] <= q.wdata;
    end
  end

  // pointers and count; flush beats both
  always_ff @(posedge i_clk) begin
    if (i_srst || (i_ce && q.flush)) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (i_ce) begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + LW'(do_push) - LW'(do_pop);
    end
  end

  // ==========================================================
  // checks
  a_no_wrap_count: assert property (@(posedge i_clk) disable iff (i_srst)
    count <= LW'(DEPTH)) else $error("store count above depth");
endmodule : arpq_store

// ---- testbench.sv ----
/*
  self-checking bench of the receive packet queue: drives the link
  side itself and the register side through the host model.
  assumes a 50 MHz clock and the queue at its default depth of 16.
*/
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // signals
  logic                 clk;          // system clock
  logic                 srst;         // sync reset
  logic [7:0]           addr;         // register offset
  logic [31:0]          wdata;        // write data
  logic                 wr;           // write strobe
  logic                 rd;           // read strobe
  logic [31:0]          rdata;        // read data
  logic                 not_empty;    // queue holds data
  logic                 pkt_start;    // packet start pulse
  arpq_pkg::arpq_src_t  pkt_src;      // origin
  logic                 pkt_agent;    // bound for agent
  arpq_pkg::arpq_cond_t pkt_cond;     // how it ended
  logic                 pkt_req;      // sent one was request
  logic [1:0]           pkt_spd;      // speed code
  logic [3:0]           pkt_ack;      // ack code
  logic                 q_valid;      // quadlet strobe
  logic [31:0]          q_data;       // raw quadlet
  logic                 q_last;       // last quadlet
  logic [31:0]          exp_q[$];     // words the data port owes
  int                   fail_count;   // mismatches
  int                   n_compared;   // comparisons
  int                   cycles;       // timeout counter
  // ==========================================================
  // clock, timeout
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ceiling well above the few hundred cycles the tests take
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end
  // ==========================================================
  // instances; clock enable tied on, freeze left unexercised
  arpq_queue #(.DEPTH(16)) arpq_queue_inst (
    .i_clk(clk), .i_srst(srst), .i_ce(1'b1), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_not_empty(not_empty),
    .i_pkt_start(pkt_start), .i_pkt_src(pkt_src), .i_pkt_to_agent(pkt_agent),
    .i_pkt_cond(pkt_cond), .i_pkt_is_req(pkt_req), .i_pkt_spd(pkt_spd),
    .i_pkt_ack(pkt_ack), .i_q_valid(q_valid), .i_q_data(q_data), .i_q_last(q_last));
  arpq_host arpq_host_inst (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic regchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    arpq_host_inst.rd(a, d);
    check(d, exp);
  endtask : regchk
  // one packet: start then n raw quadlets; keep says whether it is queued
  task automatic send(input arpq_pkg::arpq_src_t src, input logic agent, keep,
                      input arpq_pkg::arpq_cond_t c, input logic req,
                      input logic [1:0] sp, input logic [3:0] st, tc, input int n);
    logic [31:0] w;
    if (keep) exp_q.push_back({st, 10'h000, sp, 12'h000, ~st});
    @(posedge clk);
    pkt_start <= 1'b1;
    pkt_src   <= src;
    pkt_agent <= agent;
    pkt_cond  <= c;
    pkt_req   <= req;
    pkt_spd   <= sp;
    pkt_ack   <= ~st;
    for (int i = 0; i < n; i++) begin
      w = {16'h5A00 + 16'(i), 8'h00, tc, 4'hF}; // priority bits set on purpose
      @(posedge clk);
      pkt_start <= 1'b0;
      pkt_spd   <= ~sp;
      q_valid   <= 1'b1;
      q_data    <= w;
      q_last    <= (i == n - 1);
      if (keep && !((tc == 4'h2 || tc == 4'h4) && i >= 3) && !(tc == 4'h5 && i >= 4))
        exp_q.push_back((i == 0) ? {w[31:4], 4'h0} : w);
    end
    @(posedge clk);
    q_valid <= 1'b0;
    q_last  <= 1'b0;
    q_data  <= ~w;
  endtask : send
  // read the data port until every owed word is seen
  task automatic drain();
    logic [31:0] d;
    while (exp_q.size() > 0) begin
      arpq_host_inst.rd(8'h80, d);
      check(d, exp_q.pop_front());
    end
    regchk(8'h80, 32'h0000_0000);
  endtask : drain
  task automatic summarize();
    $display("compared %0d, wrong %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  // ==========================================================
  // scenarios
  task automatic t_reset();
    regchk(8'h30, 32'h0000_0101);
    regchk(8'h08, 32'h0000_0000);
    regchk(8'h44, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset
  // quadlet packets: payload only for write request and read response
  task automatic t_quad();
    send(arpq_pkg::ARPQ_S_NODE_REQ, 1'b0, 1'b1, arpq_pkg::ARPQ_C_COMPLETE, 1'b1,
         2'b01, 4'h0, 4'h0, 4);
    send(arpq_pkg::ARPQ_S_NODE_REQ, 1'b0, 1'b1, arpq_pkg::ARPQ_C_COMPLETE, 1'b1,
         2'b10, 4'h0, 4'h4, 4);
    check(32'(not_empty), 32'h0000_0001);
    regchk(8'h30, 32'h0009_0001);
    drain();
    send(arpq_pkg::ARPQ_S_TX_RESP, 1'b0, 1'b1, arpq_pkg::ARPQ_C_COMPLETE, 1'b0,
         2'b00, 4'h0, 4'h6, 4);
    send(arpq_pkg::ARPQ_S_TX_RESP, 1'b0, 1'b1, arpq_pkg::ARPQ_C_COMPLETE, 1'b0,
         2'b00, 4'h0, 4'h2, 4);
    drain();
    $display("test quadlet done");
  endtask : t_quad
  // block packets: data kept for write request, dropped for read request
  task automatic t_block();
    send(arpq_pkg::ARPQ_S_NODE_REQ, 1'b0, 1'b1, arpq_pkg::ARPQ_C_COMPLETE, 1'b1,
         2'b01, 4'h0, 4'h1, 6);
    send(arpq_pkg::ARPQ_S_NODE_REQ, 1'b0, 1'b1, arpq_pkg::ARPQ_C_COMPLETE, 1'b1,
         2'b01, 4'h0, 4'h5, 6);
    drain();
    $display("test block done");
  endtask : t_block
  // every ending condition, every speed code, split on and off
  task automatic t_status();
    logic [3:0] st [7] = '{4'h0, 4'h1, 4'h2, 4'h2, 4'h3, 4'h4, 4'h5};
    for (int i = 0; i < 7; i++) begin
      send(arpq_pkg::ARPQ_S_TX_RESP, 1'b0, 1'b1, arpq_pkg::arpq_cond_t'(i), 1'b1,
           2'(i), st[i], 4'h2, 3);
      drain();
    end
    arpq_host_inst.wr(8'h08, 32'h0000_0001);
    regchk(8'h08, 32'h0000_0001);
    send(arpq_pkg::ARPQ_S_TX_RESP, 1'b0, 1'b1, arpq_pkg::ARPQ_C_PEND, 1'b1,
         2'b00, 4'h0, 4'h2, 3);
    send(arpq_pkg::ARPQ_S_TX_RESP, 1'b0, 1'b1, arpq_pkg::ARPQ_C_PEND, 1'b0,
         2'b00, 4'h2, 4'h2, 3);
    drain();
    arpq_host_inst.wr(8'h08, 32'h0000_0000);
    $display("test status done");
  endtask : t_status
  // agent-bound, foreign and disabled-queue packets leave no trace
  task automatic t_drop();
    send(arpq_pkg::ARPQ_S_NODE_REQ, 1'b1, 1'b0, arpq_pkg::ARPQ_C_COMPLETE, 1'b1,
         2'b00, 4'h0, 4'h0, 4);
    send(arpq_pkg::ARPQ_S_OTHER, 1'b0, 1'b0, arpq_pkg::ARPQ_C_COMPLETE, 1'b1,
         2'b00, 4'h0, 4'h0, 4);
    arpq_host_inst.wr(8'h30, 32'h0000_0000);
    send(arpq_pkg::ARPQ_S_TX_RESP, 1'b0, 1'b0, arpq_pkg::ARPQ_C_COMPLETE, 1'b0,
         2'b00, 4'h0, 4'h6, 4);
    regchk(8'h30, 32'h0000_0100);
    arpq_host_inst.wr(8'h30, 32'h0000_0001);
    send(arpq_pkg::ARPQ_S_TX_RESP, 1'b0, 1'b1, arpq_pkg::ARPQ_C_COMPLETE, 1'b0,
         2'b00, 4'h0, 4'h6, 4);
    drain();
    $display("test drop done");
  endtask : t_drop
  // fill past full, clear the sticky overflow, then flush
  task automatic t_ovf();
    for (int i = 0; i < 4; i++) begin
      send(arpq_pkg::ARPQ_S_NODE_REQ, 1'b0, 1'b1, arpq_pkg::ARPQ_C_COMPLETE, 1'b1,
           2'b00, 4'h0, 4'h0, 4);
    end
    regchk(8'h30, 32'h0010_0601);
    arpq_host_inst.wr(8'h30, 32'h0000_0003);
    regchk(8'h30, 32'h0010_0201);
    arpq_host_inst.wr(8'h30, 32'h0000_0005);
    exp_q.delete();
    regchk(8'h30, 32'h0000_0101);
    drain();
    $display("test overflow done");
  endtask : t_ovf
  // ==========================================================
  // main sequence
  initial begin
    fail_count = 0;
    n_compared = 0;
    cycles     = 0;
    srst       = 1'b1;
    pkt_start  = 1'b0;
    pkt_src    = arpq_pkg::ARPQ_S_OTHER;
    pkt_agent  = 1'b0;
    pkt_cond   = arpq_pkg::ARPQ_C_COMPLETE;
    pkt_req    = 1'b0;
    pkt_spd    = 2'b00;
    pkt_ack    = 4'h0;
    q_valid    = 1'b0;
    q_data     = 32'h0000_0000;
    q_last     = 1'b0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_quad();
    t_block();
    t_status();
    t_drop();
    t_ovf();
    summarize();
  end
endmodule : testbench
